// File: rtl/rotate_sub_skip_defs.svh
`ifndef ROTATE_SUB_SKIP_DEFS_SVH
`define ROTATE_SUB_SKIP_DEFS_SVH
// Overview of operation
// - left rotate through carry to memory: bit 7 to carry, carry to bit 0
// - same nine-bit left rotation into accumulator; memory untouched, carry gets bit 7
// - plain right rotate of memory byte, bit 0 into bit 7, no flags change
// - plain right rotate into accumulator; memory and flags unchanged
// - right rotate through carry to memory: bit 0 to carry, carry to bit 7
// - nine-bit right rotation into accumulator; carry from bit 0; memory kept
// - subtract with borrow: acc + ~mem + carry, to acc or memory, all four flags
// - subtract: acc + ~operand + 1, operand memory or immediate, all four flags
// - decrement memory, write back, skip when result is zero, flags kept
// - decrement into accumulator, memory kept, skip when zero, flags kept
// - increment memory, write back, skip when result is zero, flags kept
// - increment into accumulator, memory kept, skip when zero, flags kept
// - a taken skip adds one dummy cycle: 2 cycles, otherwise 1 cycle
// - bit test skips next instruction when the selected memory bit is one
// - byte fill writes all ones to memory, flags kept
// - bit set forces only the selected memory bit high, flags kept
// - nibble exchange in memory in place, flags kept
// - nibble exchange into accumulator, memory kept

// register byte offsets
`define REG_CTRL 6'h00
`define REG_ACC 6'h04
`define REG_MEM 6'h08
`define REG_IMM 6'h0c
`define REG_FLAGS 6'h10
`define REG_STATE 6'h14

// control register fields
`define CTRL_OP_MSB 4
`define CTRL_OP_LSB 0
`define CTRL_BIT_MSB 10
`define CTRL_BIT_LSB 8

// flag register bit positions
`define FLAG_C 0
`define FLAG_AC 1
`define FLAG_Z 2
`define FLAG_OV 3

// state register fields
`define STATE_BUSY 0
`define STATE_SKIP 1
`define STATE_CYC_LSB 4
`define STATE_CYC_MSB 5

// reset values and constants
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hff
`define WORD_ZERO 32'h0000_0000
`define CYC_PLAIN 2'h1
`define CYC_SKIPPED 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// operation codes
`define OPC_LEFT_ROTATE_CY_MEM 5'h00
`define OPC_LEFT_ROTATE_CY_TO_ACC 5'h01
`define OPC_RIGHT_ROTATE_MEM 5'h02
`define OPC_RIGHT_ROTATE_TO_ACC 5'h03
`define OPC_RIGHT_ROTATE_CY_MEM 5'h04
`define OPC_RIGHT_ROTATE_CY_TO_ACC 5'h05
`define OPC_BORROW_SUBTRACT_TO_ACC 5'h06
`define OPC_BORROW_SUBTRACT_TO_MEM 5'h07
`define OPC_DIFFERENCE_MEM_TO_ACC 5'h08
`define OPC_DIFFERENCE_IMM_TO_ACC 5'h09
`define OPC_DIFFERENCE_TO_MEM 5'h0a
`define OPC_DECREMENT_SKIP_ON_NIL 5'h0b
`define OPC_DECREMENT_TO_ACC_SKIP 5'h0c
`define OPC_INCREMENT_SKIP_ON_NIL 5'h0d
`define OPC_INCREMENT_TO_ACC_SKIP 5'h0e
`define OPC_BIT_HIGH_SKIP 5'h0f
`define OPC_BYTE_FILL 5'h10
`define OPC_BIT_FORCE_HIGH 5'h11
`define OPC_NIBBLE_EXCHANGE_MEM 5'h12
`define OPC_NIBBLE_EXCHANGE_TO_ACC 5'h13

// one-hot state codes
`define ST_CODE_IDLE 3'b001
`define ST_CODE_EXEC 3'b010
`define ST_CODE_DUMMY 3'b100
`endif

// File: rtl/rotate_sub_skip_pkg.sv
`include "rotate_sub_skip_defs.svh"

package rotate_sub_skip_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = `ST_CODE_IDLE,
		ST_EXEC = `ST_CODE_EXEC,
		ST_DUMMY = `ST_CODE_DUMMY
	} state_t;

	typedef enum logic [4:0] {
		OP_LEFT_ROTATE_CY_MEM = `OPC_LEFT_ROTATE_CY_MEM,
		OP_LEFT_ROTATE_CY_TO_ACC = `OPC_LEFT_ROTATE_CY_TO_ACC,
		OP_RIGHT_ROTATE_MEM = `OPC_RIGHT_ROTATE_MEM,
		OP_RIGHT_ROTATE_TO_ACC = `OPC_RIGHT_ROTATE_TO_ACC,
		OP_RIGHT_ROTATE_CY_MEM = `OPC_RIGHT_ROTATE_CY_MEM,
		OP_RIGHT_ROTATE_CY_TO_ACC = `OPC_RIGHT_ROTATE_CY_TO_ACC,
		OP_BORROW_SUBTRACT_TO_ACC = `OPC_BORROW_SUBTRACT_TO_ACC,
		OP_BORROW_SUBTRACT_TO_MEM = `OPC_BORROW_SUBTRACT_TO_MEM,
		OP_DIFFERENCE_MEM_TO_ACC = `OPC_DIFFERENCE_MEM_TO_ACC,
		OP_DIFFERENCE_IMM_TO_ACC = `OPC_DIFFERENCE_IMM_TO_ACC,
		OP_DIFFERENCE_TO_MEM = `OPC_DIFFERENCE_TO_MEM,
		OP_DECREMENT_SKIP_ON_NIL = `OPC_DECREMENT_SKIP_ON_NIL,
		OP_DECREMENT_TO_ACC_SKIP = `OPC_DECREMENT_TO_ACC_SKIP,
		OP_INCREMENT_SKIP_ON_NIL = `OPC_INCREMENT_SKIP_ON_NIL,
		OP_INCREMENT_TO_ACC_SKIP = `OPC_INCREMENT_TO_ACC_SKIP,
		OP_BIT_HIGH_SKIP = `OPC_BIT_HIGH_SKIP,
		OP_BYTE_FILL = `OPC_BYTE_FILL,
		OP_BIT_FORCE_HIGH = `OPC_BIT_FORCE_HIGH,
		OP_NIBBLE_EXCHANGE_MEM = `OPC_NIBBLE_EXCHANGE_MEM,
		OP_NIBBLE_EXCHANGE_TO_ACC = `OPC_NIBBLE_EXCHANGE_TO_ACC
	} op_t;
endpackage

// File: rtl/complement_adder.sv
// a + ~b + cin with carry, half carry and signed range flags
module complement_adder #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] a,
	input wire logic [WIDTH-1:0] b,
	input wire logic cin,
	output logic [WIDTH-1:0] sum,
	output logic cout,
	output logic half_cout,
	output logic range_out
);
	logic [WIDTH:0] full;
	logic [4:0] low;
	logic [WIDTH-1:0] top;

	always_comb begin
		full = {1'b0, a} + {1'b0, ~b} + {{WIDTH{1'b0}}, cin};
		low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
		top = {1'b0, a[WIDTH-2:0]} + {1'b0, ~b[WIDTH-2:0]} + {{(WIDTH-1){1'b0}}, cin};
		sum = full[WIDTH-1:0];
		// no borrow leaves carry set
		cout = full[WIDTH];
		half_cout = low[4];
		range_out = full[WIDTH] ^ top[WIDTH-1];
	end
endmodule

// File: rtl/byte_reshaper.sv
`include "rotate_sub_skip_defs.svh"

// rotates, steps, fills, bit set/test and nibble exchange of one byte
module byte_reshaper
	import rotate_sub_skip_pkg::*;
(
	input wire op_t op,
	input wire logic [7:0] din,
	input wire logic cin,
	input wire logic [2:0] bit_sel,
	output logic [7:0] dout,
	output logic cout,
	output logic bit_val
);
	always_comb begin
		dout = din;
		cout = cin;
		bit_val = din[bit_sel];
		case (op)
			OP_LEFT_ROTATE_CY_MEM, OP_LEFT_ROTATE_CY_TO_ACC: begin
				dout = {din[6:0], cin};
				cout = din[7];
			end
			OP_RIGHT_ROTATE_MEM, OP_RIGHT_ROTATE_TO_ACC: begin
				dout = {din[0], din[7:1]};
			end
			OP_RIGHT_ROTATE_CY_MEM, OP_RIGHT_ROTATE_CY_TO_ACC: begin
				dout = {cin, din[7:1]};
				cout = din[0];
			end
			OP_DECREMENT_SKIP_ON_NIL, OP_DECREMENT_TO_ACC_SKIP: begin
				dout = din - 8'h01;
			end
			OP_INCREMENT_SKIP_ON_NIL, OP_INCREMENT_TO_ACC_SKIP: begin
				dout = din + 8'h01;
			end
			OP_BYTE_FILL: begin
				dout = `BYTE_ONES;
			end
			OP_BIT_FORCE_HIGH: begin
				dout = din | (8'h01 << bit_sel);
			end
			OP_NIBBLE_EXCHANGE_MEM, OP_NIBBLE_EXCHANGE_TO_ACC: begin
				dout = {din[3:0], din[7:4]};
			end
			default: begin
				dout = din;
			end
		endcase
	end
endmodule

// File: rtl/rotate_sub_skip_alu.sv
`include "rotate_sub_skip_defs.svh"

module rotate_sub_skip_alu
	import rotate_sub_skip_pkg::*;
#(
	parameter int ADDR_W = 6
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// write address channel
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	// write data channel
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// write response channel
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// read address channel
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	// read data channel
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	// bus side state
	logic aw_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic do_write;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_word;

	// datapath state
	state_t state_reg;
	state_t state_next;
	op_t op_reg;
	logic [2:0] bit_sel_reg;
	logic [7:0] acc_reg;
	logic [7:0] mem_reg;
	logic [7:0] imm_reg;
	logic c_reg;
	logic ac_reg;
	logic z_reg;
	logic ov_reg;
	logic skip_reg;
	logic [1:0] cycles_reg;

	// decoded result of the current operation
	logic [7:0] result;
	logic to_acc;
	logic to_mem;
	logic c_next;
	logic arith;
	logic skip;
	logic [7:0] sub_b;
	logic sub_cin;
	logic [7:0] sub_sum;
	logic sub_c;
	logic sub_ac;
	logic sub_ov;
	logic [7:0] shape_res;
	logic shape_c;
	logic bit_val;
	logic busy;
	logic exec;
	logic start;

	assign AWREADY = awready_reg;
	assign WREADY = wready_reg;
	assign BVALID = bvalid_reg;
	assign BRESP = bresp_reg;
	assign ARREADY = arready_reg;
	assign RVALID = rvalid_reg;
	assign RDATA = rdata_reg;
	assign RRESP = rresp_reg;

	assign busy = (state_reg != ST_IDLE);
	assign exec = (state_reg == ST_EXEC);
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

	function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [5:0] off);
		addr_is = ({addr[5:2], 2'h0} == off) && ((addr >> 6) == '0);
	endfunction

	always_comb begin
		wr_hit = addr_is(aw_addr_reg, `REG_CTRL) || addr_is(aw_addr_reg, `REG_ACC) ||
			addr_is(aw_addr_reg, `REG_MEM) || addr_is(aw_addr_reg, `REG_IMM) ||
			addr_is(aw_addr_reg, `REG_FLAGS);
		rd_hit = wr_hit;
		rd_word = `WORD_ZERO;
		rd_hit = 1'b1;
		if (addr_is(ARADDR, `REG_CTRL)) begin
			rd_word[`CTRL_OP_MSB:`CTRL_OP_LSB] = op_reg;
			rd_word[`CTRL_BIT_MSB:`CTRL_BIT_LSB] = bit_sel_reg;
		end else if (addr_is(ARADDR, `REG_ACC)) begin
			rd_word[7:0] = acc_reg;
		end else if (addr_is(ARADDR, `REG_MEM)) begin
			rd_word[7:0] = mem_reg;
		end else if (addr_is(ARADDR, `REG_IMM)) begin
			rd_word[7:0] = imm_reg;
		end else if (addr_is(ARADDR, `REG_FLAGS)) begin
			rd_word[`FLAG_C] = c_reg;
			rd_word[`FLAG_AC] = ac_reg;
			rd_word[`FLAG_Z] = z_reg;
			rd_word[`FLAG_OV] = ov_reg;
		end else if (addr_is(ARADDR, `REG_STATE)) begin
			rd_word[`STATE_BUSY] = busy;
			rd_word[`STATE_SKIP] = skip_reg;
			rd_word[`STATE_CYC_MSB:`STATE_CYC_LSB] = cycles_reg;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// write address and data are taken in either order
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			awready_reg <= 1'b1;
		end else if (AWVALID && awready_reg) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= AWADDR;
			awready_reg <= 1'b0;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end else if (bvalid_reg && BREADY) begin
			awready_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			w_held_reg <= 1'b0;
			w_data_reg <= `WORD_ZERO;
			w_strb_reg <= 4'h0;
			wready_reg <= 1'b1;
		end else if (WVALID && wready_reg) begin
			w_held_reg <= 1'b1;
			w_data_reg <= WDATA;
			w_strb_reg <= WSTRB;
			wready_reg <= 1'b0;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end else if (bvalid_reg && BREADY) begin
			wready_reg <= 1'b1;
		end
	end

	// write response, error on an unmapped address
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid_reg && BREADY) begin
			bvalid_reg <= 1'b0;
		end
	end

	// read channel answers one cycle after the address is taken
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= `WORD_ZERO;
			rresp_reg <= `RESP_OKAY;
		end else if (ARVALID && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_reg && RREADY) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// a control write starts one operation; ignored while one runs
	assign start = do_write && w_strb_reg[0] && addr_is(aw_addr_reg, `REG_CTRL) && !busy;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			op_reg <= OP_LEFT_ROTATE_CY_MEM;
			bit_sel_reg <= 3'h0;
		end else if (start) begin
			op_reg <= op_t'(w_data_reg[`CTRL_OP_MSB:`CTRL_OP_LSB]);
			bit_sel_reg <= w_data_reg[`CTRL_BIT_MSB:`CTRL_BIT_LSB];
		end
	end

	byte_reshaper u_shape (
		.op(op_reg),
		.din(mem_reg),
		.cin(c_reg),
		.bit_sel(bit_sel_reg),
		.dout(shape_res),
		.cout(shape_c),
		.bit_val(bit_val)
	);

	always_comb begin
		sub_b = (op_reg == OP_DIFFERENCE_IMM_TO_ACC) ? imm_reg : mem_reg;
		sub_cin = c_reg;
		if (op_reg != OP_BORROW_SUBTRACT_TO_ACC && op_reg != OP_BORROW_SUBTRACT_TO_MEM) begin
			sub_cin = 1'b1;
		end
	end

	complement_adder #(
		.WIDTH(8)
	) u_sub (
		.a(acc_reg),
		.b(sub_b),
		.cin(sub_cin),
		.sum(sub_sum),
		.cout(sub_c),
		.half_cout(sub_ac),
		.range_out(sub_ov)
	);

	// destination, flag and skip decode
	always_comb begin
		result = shape_res;
		to_acc = 1'b0;
		to_mem = 1'b0;
		c_next = c_reg;
		arith = 1'b0;
		skip = 1'b0;
		case (op_reg)
			OP_LEFT_ROTATE_CY_MEM, OP_RIGHT_ROTATE_CY_MEM: begin
				to_mem = 1'b1;
				c_next = shape_c;
			end
			OP_LEFT_ROTATE_CY_TO_ACC, OP_RIGHT_ROTATE_CY_TO_ACC: begin
				to_acc = 1'b1;
				c_next = shape_c;
			end
			OP_RIGHT_ROTATE_MEM, OP_BYTE_FILL, OP_BIT_FORCE_HIGH, OP_NIBBLE_EXCHANGE_MEM: begin
				to_mem = 1'b1;
			end
			OP_RIGHT_ROTATE_TO_ACC, OP_NIBBLE_EXCHANGE_TO_ACC: begin
				to_acc = 1'b1;
			end
			OP_BORROW_SUBTRACT_TO_ACC, OP_DIFFERENCE_MEM_TO_ACC, OP_DIFFERENCE_IMM_TO_ACC: begin
				result = sub_sum;
				to_acc = 1'b1;
				arith = 1'b1;
				c_next = sub_c;
			end
			OP_BORROW_SUBTRACT_TO_MEM, OP_DIFFERENCE_TO_MEM: begin
				result = sub_sum;
				to_mem = 1'b1;
				arith = 1'b1;
				c_next = sub_c;
			end
			OP_DECREMENT_SKIP_ON_NIL, OP_INCREMENT_SKIP_ON_NIL: begin
				to_mem = 1'b1;
				skip = (shape_res == `BYTE_ZERO);
			end
			OP_DECREMENT_TO_ACC_SKIP, OP_INCREMENT_TO_ACC_SKIP: begin
				to_acc = 1'b1;
				skip = (shape_res == `BYTE_ZERO);
			end
			OP_BIT_HIGH_SKIP: begin
				skip = bit_val;
			end
			default: begin
				result = shape_res;
			end
		endcase
	end

	// operation sequence: execute, then a dummy cycle when skipping
	always_comb begin
		case (state_reg)
			ST_IDLE: state_next = start ? ST_EXEC : ST_IDLE;
			ST_EXEC: state_next = skip ? ST_DUMMY : ST_IDLE;
			ST_DUMMY: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			skip_reg <= 1'b0;
			cycles_reg <= 2'h0;
		end else if (exec) begin
			skip_reg <= skip;
			cycles_reg <= skip ? `CYC_SKIPPED : `CYC_PLAIN;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			acc_reg <= `BYTE_ZERO;
		end else if (exec && to_acc) begin
			acc_reg <= result;
		end else if (start == 1'b0 && do_write && !busy && w_strb_reg[0] &&
				addr_is(aw_addr_reg, `REG_ACC)) begin
			acc_reg <= w_data_reg[7:0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			mem_reg <= `BYTE_ZERO;
		end else if (exec && to_mem) begin
			mem_reg <= result;
		end else if (do_write && !busy && w_strb_reg[0] && addr_is(aw_addr_reg, `REG_MEM)) begin
			mem_reg <= w_data_reg[7:0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			imm_reg <= `BYTE_ZERO;
		end else if (do_write && !busy && w_strb_reg[0] && addr_is(aw_addr_reg, `REG_IMM)) begin
			imm_reg <= w_data_reg[7:0];
		end
	end

	// only subtracts touch range, zero and half carry; carry as decoded
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			c_reg <= 1'b0;
			ac_reg <= 1'b0;
			z_reg <= 1'b0;
			ov_reg <= 1'b0;
		end else if (exec) begin
			c_reg <= c_next;
			if (arith) begin
				ac_reg <= sub_ac;
				z_reg <= (sub_sum == `BYTE_ZERO);
				ov_reg <= sub_ov;
			end
		end else if (do_write && !busy && w_strb_reg[0] && addr_is(aw_addr_reg, `REG_FLAGS)) begin
			c_reg <= w_data_reg[`FLAG_C];
			ac_reg <= w_data_reg[`FLAG_AC];
			z_reg <= w_data_reg[`FLAG_Z];
			ov_reg <= w_data_reg[`FLAG_OV];
		end
	end
endmodule

// File: verification/rotate_sub_skip_alu_properties.sv
module rotate_sub_skip_alu_properties #(
	parameter int ADDR_W = 6
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// write side
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	// read side
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RVALID,
	input wire logic RREADY
);
	timeunit 1ns;
	timeprecision 1ns;
	logic aw_bad_reg;

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	// remembers whether the accepted write address is outside the writable map
	always_ff @(posedge CLK_SYS) begin
		if (RST)
			aw_bad_reg <= 1'h0;
		else if (AWVALID && AWREADY)
			aw_bad_reg <= AWADDR[5:2] > 4'h4;
	end

	bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped before acceptance");
	rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
		else $error("read data dropped before acceptance");
	read_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("read answer not one cycle after address");
	read_err_a: assert property (ARVALID && ARREADY && ARADDR[5:2] > 4'h5 |=> RRESP == 2'h2 && RDATA == 32'h0)
		else $error("unmapped read not refused");
	read_ok_a: assert property (ARVALID && ARREADY && ARADDR[5:2] < 4'h6 |=> RRESP == 2'h0)
		else $error("mapped read refused");
	write_answer_a: assert property (!AWREADY && !WREADY && !BVALID |=> BVALID)
		else $error("write response late");
	write_resp_a: assert property (BVALID |-> BRESP == (aw_bad_reg ? 2'h2 : 2'h0))
		else $error("write response code wrong");
	b_release_a: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
		else $error("write channel not released");
	no_early_b_a: assert property (AWREADY && !BVALID |=> !BVALID)
		else $error("write response before address taken");
	state_cycles_a: assert property (ARVALID && ARREADY && ARADDR == 6'h14 |=>
		(RDATA[1] ? RDATA[5:4] == 2'h2 : RDATA[5:4] < 2'h2))
		else $error("cycle count disagrees with skip");
	upper_zero_a: assert property (RVALID |-> RDATA[31:11] == 21'h0)
		else $error("unused read bits not zero");
endmodule

bind rotate_sub_skip_alu rotate_sub_skip_alu_properties #(.ADDR_W(ADDR_W)) props_inst (
	.CLK_SYS(CLK_SYS), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
	.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
	.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
	.RREADY(RREADY));

// File: verification/rotate_sub_skip_alu_tb_top.sv
`include "rotate_sub_skip_defs.svh"

module rotate_sub_skip_alu_tb_top
	import rotate_sub_skip_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_SYS, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY;
	logic [5:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, d;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, r;
	int n_mismatch = 0;
	int comparisons = 0;
	int k;

	rotate_sub_skip_alu rotate_sub_skip_alu_inst (.CLK_SYS(CLK_SYS), .RST(RST), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
		.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY));

	initial begin
		CLK_SYS = 1'h0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end

	task give_verdict;
		$display("counts: %0d compared, %0d mismatched", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task tmo;
		chk("handshake wait", 32'h1, 32'h0);
		give_verdict();
	endtask

	// ready is raised only once the answer shows, so every answer is stalled a cycle
	task automatic wr(input logic [5:0] a, input logic [31:0] dat, input logic [1:0] er);
		int i;
		@(posedge CLK_SYS);
		AWADDR <= a;
		WDATA <= dat;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		for (i = 0; i < 20; i++) begin
			@(posedge CLK_SYS);
			if (AWVALID && AWREADY) AWVALID <= 1'h0;
			if (WVALID && WREADY) WVALID <= 1'h0;
			if (BVALID && BREADY) break;
			if (BVALID) BREADY <= 1'h1;
		end
		if (i == 20) tmo();
		BREADY <= 1'h0;
		chk("write response", {30'h0, er}, {30'h0, BRESP});
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] dat, output logic [1:0] rs);
		int i;
		@(posedge CLK_SYS);
		ARADDR <= a;
		ARVALID <= 1'h1;
		for (i = 0; i < 20; i++) begin
			@(posedge CLK_SYS);
			if (ARVALID && ARREADY) ARVALID <= 1'h0;
			if (RVALID && RREADY) break;
			if (RVALID) RREADY <= 1'h1;
		end
		if (i == 20) tmo();
		dat = RDATA;
		rs = RRESP;
		RREADY <= 1'h0;
	endtask

	task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
		logic [31:0] dat;
		logic [1:0] rs;
		rd(a, dat, rs);
		chk(nm, e, dat);
		chk("read response", 32'h0, {30'h0, rs});
	endtask

	// reference results of one operation
	task automatic model(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] a, m, x,
		input logic [3:0] f, output logic [7:0] ea, em, output logic [3:0] ef, output logic sk);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] l, b;
		logic ci;
		ea = a;
		em = m;
		ef = f;
		sk = 1'h0;
		b = (op == OP_DIFFERENCE_IMM_TO_ACC) ? x : m;
		ci = (op == OP_BORROW_SUBTRACT_TO_ACC || op == OP_BORROW_SUBTRACT_TO_MEM) ? f[0] : 1'h1;
		s = {1'h0, a} + {1'h0, ~b} + 9'(ci);
		h = {1'h0, a[3:0]} + {1'h0, ~b[3:0]} + 5'(ci);
		l = {1'h0, a[6:0]} + {1'h0, ~b[6:0]} + 8'(ci);
		case (op)
			OP_LEFT_ROTATE_CY_MEM: {ef[0], em} = {m, f[0]};
			OP_LEFT_ROTATE_CY_TO_ACC: {ef[0], ea} = {m, f[0]};
			OP_RIGHT_ROTATE_MEM: em = {m[0], m[7:1]};
			OP_RIGHT_ROTATE_TO_ACC: ea = {m[0], m[7:1]};
			OP_RIGHT_ROTATE_CY_MEM: {em, ef[0]} = {f[0], m};
			OP_RIGHT_ROTATE_CY_TO_ACC: {ea, ef[0]} = {f[0], m};
			OP_BORROW_SUBTRACT_TO_ACC, OP_DIFFERENCE_MEM_TO_ACC: ea = s[7:0];
			OP_DIFFERENCE_IMM_TO_ACC: ea = s[7:0];
			OP_BORROW_SUBTRACT_TO_MEM, OP_DIFFERENCE_TO_MEM: em = s[7:0];
			OP_DECREMENT_SKIP_ON_NIL: em = m - 8'h1;
			OP_DECREMENT_TO_ACC_SKIP: ea = m - 8'h1;
			OP_INCREMENT_SKIP_ON_NIL: em = m + 8'h1;
			OP_INCREMENT_TO_ACC_SKIP: ea = m + 8'h1;
			OP_BIT_HIGH_SKIP: sk = m[bs];
			OP_BYTE_FILL: em = 8'hff;
			OP_BIT_FORCE_HIGH: em = m | (8'h1 << bs);
			OP_NIBBLE_EXCHANGE_MEM: em = {m[3:0], m[7:4]};
			OP_NIBBLE_EXCHANGE_TO_ACC: ea = {m[3:0], m[7:4]};
			default: ;
		endcase
		if (op == OP_DECREMENT_SKIP_ON_NIL || op == OP_INCREMENT_SKIP_ON_NIL) sk = em == 8'h0;
		if (op == OP_DECREMENT_TO_ACC_SKIP || op == OP_INCREMENT_TO_ACC_SKIP) sk = ea == 8'h0;
		if (op >= OP_BORROW_SUBTRACT_TO_ACC && op <= OP_DIFFERENCE_TO_MEM)
			ef = {l[7] ^ s[8], s[7:0] == 8'h0, h[4], s[8]};
	endtask

	task automatic run(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] a, m, x,
		input logic [3:0] f);
		logic [7:0] ea, em;
		logic [3:0] ef;
		logic sk;
		logic [31:0] dat;
		logic [1:0] rs;
		int i;
		model(op, bs, a, m, x, f, ea, em, ef, sk);
		wr(`REG_ACC, {24'h0, a}, 2'h0);
		wr(`REG_MEM, {24'h0, m}, 2'h0);
		wr(`REG_IMM, {24'h0, x}, 2'h0);
		wr(`REG_FLAGS, {28'h0, f}, 2'h0);
		wr(`REG_CTRL, {21'h0, bs, 3'h0, op}, 2'h0);
		for (i = 0; i < 10; i++) begin
			rd(`REG_STATE, dat, rs);
			if (dat[0] === 1'h0) break;
		end
		if (i == 10) tmo();
		chk("state", {26'h0, (sk ? 2'h2 : 2'h1), 2'h0, sk, 1'h0}, dat);
		rchk("acc", `REG_ACC, {24'h0, ea});
		rchk("mem", `REG_MEM, {24'h0, em});
		rchk("flags", `REG_FLAGS, {28'h0, ef});
		$display("test op %h done", op);
	endtask

	initial begin
		RST <= 1'h1;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} <= 5'h0;
		AWADDR <= 6'h0;
		ARADDR <= 6'h0;
		WDATA <= 32'h0;
		WSTRB <= 4'h1;
		repeat (6) @(posedge CLK_SYS);
		RST <= 1'h0;
		for (k = 0; k < 6; k++) rchk("reset value", 6'(k * 4), 32'h0);
		$display("test reset done");
		rd(6'h18, d, r);
		chk("unmapped data", 32'h0, d);
		chk("unmapped response", 32'h2, {30'h0, r});
		wr(6'h1c, 32'hff, 2'h2);
		wr(`REG_STATE, 32'h33, 2'h2);
		rchk("read-only state", `REG_STATE, 32'h0);
		WSTRB <= 4'he;
		wr(`REG_ACC, 32'h5a, 2'h0);
		WSTRB <= 4'h1;
		rchk("masked write", `REG_ACC, 32'h0);
		$display("test bus done");
		run(OP_LEFT_ROTATE_CY_MEM, 3'h0, 8'h00, 8'h81, 8'h00, 4'he);
		run(OP_LEFT_ROTATE_CY_TO_ACC, 3'h0, 8'h55, 8'h7f, 8'h00, 4'h1);
		run(OP_RIGHT_ROTATE_MEM, 3'h0, 8'h00, 8'h01, 8'h00, 4'ha);
		run(OP_RIGHT_ROTATE_TO_ACC, 3'h0, 8'h00, 8'h02, 8'h00, 4'h5);
		run(OP_RIGHT_ROTATE_CY_MEM, 3'h0, 8'h00, 8'h01, 8'h00, 4'h0);
		run(OP_RIGHT_ROTATE_CY_TO_ACC, 3'h0, 8'h11, 8'h80, 8'h00, 4'h1);
		run(OP_BORROW_SUBTRACT_TO_ACC, 3'h0, 8'h10, 8'h01, 8'h00, 4'h0);
		run(OP_BORROW_SUBTRACT_TO_MEM, 3'h0, 8'h80, 8'h01, 8'h00, 4'h1);
		run(OP_DIFFERENCE_MEM_TO_ACC, 3'h0, 8'h05, 8'h05, 8'h00, 4'h0);
		run(OP_DIFFERENCE_IMM_TO_ACC, 3'h0, 8'h03, 8'h00, 8'h04, 4'h1);
		run(OP_DIFFERENCE_TO_MEM, 3'h0, 8'h7f, 8'hff, 8'h00, 4'h0);
		run(OP_DECREMENT_SKIP_ON_NIL, 3'h0, 8'h00, 8'h01, 8'h00, 4'h9);
		run(OP_DECREMENT_SKIP_ON_NIL, 3'h0, 8'h00, 8'h00, 8'h00, 4'h6);
		run(OP_DECREMENT_TO_ACC_SKIP, 3'h0, 8'h33, 8'h01, 8'h00, 4'hf);
		run(OP_INCREMENT_SKIP_ON_NIL, 3'h0, 8'h00, 8'hff, 8'h00, 4'h0);
		run(OP_INCREMENT_SKIP_ON_NIL, 3'h0, 8'h00, 8'h7f, 8'h00, 4'h3);
		run(OP_INCREMENT_TO_ACC_SKIP, 3'h0, 8'h44, 8'hff, 8'h00, 4'hc);
		run(OP_BIT_HIGH_SKIP, 3'h3, 8'h00, 8'h08, 8'h00, 4'h0);
		run(OP_BIT_HIGH_SKIP, 3'h7, 8'h00, 8'h7f, 8'h00, 4'h0);
		run(OP_BYTE_FILL, 3'h0, 8'h00, 8'h12, 8'h00, 4'h5);
		run(OP_BIT_FORCE_HIGH, 3'h7, 8'h00, 8'h00, 8'h00, 4'ha);
		run(OP_BIT_FORCE_HIGH, 3'h0, 8'h00, 8'hfe, 8'h00, 4'h0);
		run(OP_NIBBLE_EXCHANGE_MEM, 3'h0, 8'h00, 8'ha5, 8'h00, 4'h3);
		run(OP_NIBBLE_EXCHANGE_TO_ACC, 3'h0, 8'h00, 8'h3c, 8'h00, 4'h0);
		run(5'h14, 3'h0, 8'h21, 8'h42, 8'h00, 4'h7);
		give_verdict();
	end
endmodule
